// File: rtl/mci_host.sv
// Carrier end of the control bus: APB slave that runs port cycles.
`timescale 1ns/100ps
module mci_host (
	input wire logic i_core_clk, // host clock
	input wire logic i_nrst, // async reset, active low
	input wire logic i_psel, // APB select
	input wire logic i_penable, // APB enable
	input wire logic i_pwrite, // APB direction
	input wire logic [11:0] i_paddr, // APB byte address
	input wire logic [31:0] i_pwdata, // APB write data
	output logic [31:0] o_prdata, // APB read data
	output logic o_pready, // APB ready
	output logic o_pslverr, // APB error
	mci_if.host_end bus, // module side
	input wire logic [3:0] i_host_flags, // host drivers for flags 0-3
	output logic [3:0] o_host_flags // flags 4-7 seen by host
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		mci_pkg::mci_state_t fsm;
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic [7:0] rdata;
		logic mrst_n;
		logic [1:0] boot;
		logic s_q;
		logic s_s;
		logic [3:0] f_q;
		logic [3:0] f_s;
	} mci_host_t;

	mci_host_t st;
	mci_host_t next_st;
	logic acc;
	logic hit;

	assign acc = i_psel & i_penable;
	assign hit = (i_paddr == mci_pkg::APB_CMD) |
		(i_paddr == mci_pkg::APB_STAT) |
		(i_paddr == mci_pkg::APB_CTRL) |
		(i_paddr == mci_pkg::APB_FLAGS);

	always_comb
	begin
		next_st = st;
		next_st.s_q = bus.sense;
		next_st.s_s = st.s_q;
		next_st.f_q = bus.mod_flags[7:4];
		next_st.f_s = st.f_q;
		case (st.fsm)
			mci_pkg::MCI_IDLE:
			begin
				if (acc && i_pwrite && i_paddr == mci_pkg::APB_CMD)
				begin
					next_st.addr = i_pwdata[mci_pkg::CMD_ADDR_LSB +: 4];
					next_st.wdata = i_pwdata[mci_pkg::CMD_WDATA_LSB +: 8];
					next_st.wr = i_pwdata[mci_pkg::CMD_WRITE_BIT];
					next_st.fsm = mci_pkg::MCI_SETUP;
				end
				if (acc && i_pwrite && i_paddr == mci_pkg::APB_CTRL)
				begin
					next_st.mrst_n = ~i_pwdata[mci_pkg::CTRL_MRST_BIT];
					next_st.boot = i_pwdata[mci_pkg::CTRL_BOOT_LSB +: 2];
				end
			end
			mci_pkg::MCI_SETUP: next_st.fsm = mci_pkg::MCI_STROBE;
			mci_pkg::MCI_STROBE: next_st.fsm = mci_pkg::MCI_HOLD;
			mci_pkg::MCI_HOLD:
			begin
				// Both ends share one clock. The module registers its read
				// data one cycle after the address, so it is valid from the
				// strobe cycle on. Sampling in the setup cycle would take stale data.
				if (!st.wr)
					next_st.rdata = bus.rdata;
				next_st.fsm = mci_pkg::MCI_IDLE;
			end
			default: next_st.fsm = mci_pkg::MCI_IDLE;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			st <= '0;
			st.mrst_n <= 1'b0;
		end
		else
			st <= next_st;
	end

	// ****************************************************************
	// APB answers and pins
	// ****************************************************************
	logic busy;
	assign busy = st.fsm != mci_pkg::MCI_IDLE;
	assign o_pready = 1'b1;
	assign o_pslverr = acc & ~hit;
	always_comb
	begin
		o_prdata = 32'h0000_0000;
		case (i_paddr)
			mci_pkg::APB_STAT:
			begin
				o_prdata[mci_pkg::STAT_RDATA_LSB +: 8] = st.rdata;
				o_prdata[mci_pkg::STAT_BUSY_BIT] = busy;
				o_prdata[mci_pkg::STAT_SENSE_BIT] = st.s_s;
			end
			mci_pkg::APB_CTRL:
			begin
				o_prdata[mci_pkg::CTRL_MRST_BIT] = ~st.mrst_n;
				o_prdata[mci_pkg::CTRL_BOOT_LSB +: 2] = st.boot;
			end
			mci_pkg::APB_FLAGS: o_prdata[3:0] = st.f_s;
			default: o_prdata = 32'h0000_0000;
		endcase
	end
	assign bus.addr = st.addr;
	assign bus.wdata = st.wdata;
	assign bus.wr_stb = st.fsm == mci_pkg::MCI_STROBE && st.wr;
	assign bus.rd_en = busy & ~st.wr;
	assign bus.mrst_n = st.mrst_n;
	assign bus.boot_pins = st.boot;
	assign bus.host_flags = {4'h0, i_host_flags};
	assign o_host_flags = st.f_s;
endmodule

// File: rtl/mci_if.sv
// Interface joining the carrier board controller and the module control end.
`timescale 1ns/100ps
interface mci_if;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic wr_stb;
	logic rd_en;
	logic mrst_n;
	logic [1:0] boot_pins;
	logic sense;
	logic [7:0] host_flags;
	logic [7:0] mod_flags;
	modport module_end (
		input addr, wdata, wr_stb, rd_en, mrst_n, boot_pins, host_flags,
		output rdata, sense, mod_flags
	);
	modport host_end (
		output addr, wdata, wr_stb, rd_en, mrst_n, boot_pins, host_flags,
		input rdata, sense, mod_flags
	);
endinterface

// File: rtl/mci_module.sv
// Module end of the control bus: port registers and processor controls.
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
// Operation
// - Sixteen ports over a private 8-bit bus
// - Ports 0-6 fixed, 7-F unused here
// - Reset bit per processor, 1 releases
// - Master reset forces all processors reset
// - Bits 1-7 select secondary boot mode
// - EEPROM port: cs, clock, din, dout
// - Processor-ID register drives ID pins
// - Status register shows live state
// - Mask bit per processor gates interrupt
// - Any generate write pulses enabled interrupts
// - Carrier always provides the control bus
// - EEPROM holds 64 words of 16 bits
// - Boot pins pick primary boot mode
// - Host sets boot pins before reset release
// - Module reset halts every processor at once
// - No-boot start address 0x00400004 bank 0
// - Link zero goes to primary link 4
// - Host boot uses external port buffer zero
// - PROM boot turns boot select to output
// - Sense active passes test data through
// - Module reads flags 0-3, drives 4-7
module mci_module #(
	parameter int NPROC = 8
) (
	input wire logic i_core_clk, // module clock
	input wire logic i_nrst, // async reset, active low
	mci_if.module_end bus, // carrier side
	input wire logic i_present, // at least one processor fitted
	input wire logic i_tdi, // test data in
	output logic o_tdo, // test data out
	input wire logic i_rom_serial_out_bit, // EEPROM data out pin
	output logic o_rom_select_bit, // EEPROM chip select
	output logic o_rom_serial_clock_bit, // EEPROM serial clock
	output logic o_rom_serial_in_bit, // EEPROM data in
	output logic [NPROC-1:0] o_proc_rst_n, // processor resets, low active
	output logic [NPROC-1:0] o_boot_host, // secondary boot, 1 host
	output logic [1:0] o_primary_boot, // primary boot mode code
	output logic [7:0] o_proc_id, // processor-ID configuration
	output logic [NPROC-1:0] o_lowest_interrupt_input, // irq pulses
	input wire logic [3:0] i_dev_flags, // module drivers for flags 4-7
	output logic [3:0] o_dev_flags // flags 0-3 seen by module
);
	if (NPROC < 1 || NPROC > mci_pkg::NUM_PROC)
	begin : g_bad_nproc
		$error("NPROC must be 1 to 8");
	end
	// The bit-bang port is sized for this identification memory geometry.
	if (mci_pkg::EEPROM_WORDS * mci_pkg::EEPROM_WORD_W
		!= mci_pkg::EEPROM_BITS)
	begin : g_bad_rom
		$error("identification memory geometry inconsistent");
	end

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [7:0] run;
		logic [7:0] boot;
		logic [2:0] ee;
		logic [7:0] pid;
		logic [7:0] mask;
		logic [7:0] irq;
		logic [1:0] pboot;
		logic mr_q;
		logic mr_s;
		logic do_q;
		logic do_s;
		logic [7:0] rdata;
	} mci_mod_t;

	mci_mod_t st;
	mci_mod_t next_st;
	logic [7:0] stat;

	always_comb
	begin
		stat = 8'h00;
		stat[mci_pkg::ST_SENSE_BIT] = i_present;
		stat[mci_pkg::ST_MRST_BIT] = st.mr_s;
		stat[mci_pkg::ST_ROM_SERIAL_OUT_BIT_BIT] = st.do_s;
	end

	always_comb
	begin
		next_st = st;
		next_st.mr_q = bus.mrst_n;
		next_st.mr_s = st.mr_q;
		next_st.do_q = i_rom_serial_out_bit;
		next_st.do_s = st.do_q;
		next_st.irq = 8'h00;
		// Boot pins are latched while reset is held so that they are
		// stable at release even if the host moves them afterwards.
		if (!st.mr_s)
			next_st.pboot = bus.boot_pins;
		if (bus.wr_stb)
		begin
			case (bus.addr)
				mci_pkg::PORT_RESET: next_st.run = bus.wdata;
				mci_pkg::PORT_BOOT:
					next_st.boot = bus.wdata & mci_pkg::BOOT_SEC_MASK;
				mci_pkg::PORT_EEPROM: next_st.ee = bus.wdata[2:0];
				mci_pkg::PORT_PROC_ID: next_st.pid = bus.wdata;
				mci_pkg::PORT_IRQ_MASK: next_st.mask = bus.wdata;
				mci_pkg::PORT_IRQ_GEN: next_st.irq = st.mask;
				default: next_st.irq = 8'h00;
			endcase
		end
		case (bus.addr)
			mci_pkg::PORT_RESET: next_st.rdata = st.run;
			mci_pkg::PORT_BOOT: next_st.rdata = st.boot;
			mci_pkg::PORT_EEPROM:
				next_st.rdata = {4'h0, st.do_s, 3'h0};
			mci_pkg::PORT_PROC_ID: next_st.rdata = st.pid;
			mci_pkg::PORT_STATUS: next_st.rdata = stat;
			mci_pkg::PORT_IRQ_MASK: next_st.rdata = st.mask;
			default: next_st.rdata = 8'h00;
		endcase
		// Master reset returns all port registers to power-up values; pboot follows the boot pins.
		if (!st.mr_s)
		begin
			next_st.run = mci_pkg::RESET_REG_INIT;
			next_st.boot = mci_pkg::BOOT_REG_INIT;
			next_st.ee = mci_pkg::EE_REG_INIT[2:0];
			next_st.pid = mci_pkg::ID_REG_INIT;
			next_st.mask = mci_pkg::MASK_REG_INIT;
			next_st.irq = 8'h00;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			st <= '0;
		else
			st <= next_st;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// The raw master reset is ANDed in so reset acts at once.
	genvar g;
	generate
		for (g = 0; g < NPROC; g++)
		begin : g_proc
			assign o_proc_rst_n[g] = st.run[g] & bus.mrst_n & st.mr_s;
			assign o_boot_host[g] = st.boot[g];
			assign o_lowest_interrupt_input[g] = st.irq[g];
		end
	endgenerate

	assign bus.rdata = bus.rd_en ? st.rdata : 8'h00;
	assign bus.sense = i_present;
	assign o_tdo = i_tdi;
	assign o_rom_select_bit = st.ee[mci_pkg::EE_CS_BIT];
	assign o_rom_serial_clock_bit = st.ee[mci_pkg::EE_SK_BIT];
	assign o_rom_serial_in_bit = st.ee[mci_pkg::EE_DI_BIT];
	// The primary processor's own boot logic acts on this code.
	assign o_primary_boot = st.pboot;
	assign o_proc_id = st.pid;
	assign o_dev_flags = bus.host_flags[3:0];
	assign bus.mod_flags = {i_dev_flags, 4'h0};
endmodule

// File: rtl/mci_pkg.sv
// Package with port map, field positions and encodings of the module control bus.
package mci_pkg;
	// ****************************************************************
	// Bus geometry
	// ****************************************************************
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int NUM_PROC = 8;
	// ****************************************************************
	// Port addresses
	// ****************************************************************
	localparam logic [3:0] PORT_RESET = 4'h0;
	localparam logic [3:0] PORT_BOOT = 4'h1;
	localparam logic [3:0] PORT_EEPROM = 4'h2;
	localparam logic [3:0] PORT_PROC_ID = 4'h3;
	localparam logic [3:0] PORT_STATUS = 4'h4;
	localparam logic [3:0] PORT_IRQ_MASK = 4'h5;
	localparam logic [3:0] PORT_IRQ_GEN = 4'h6;
	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int EE_CS_BIT = 0;
	localparam int EE_SK_BIT = 1;
	localparam int EE_DI_BIT = 2;
	localparam int EE_DO_BIT = 3;
	localparam int ST_SENSE_BIT = 0;
	localparam int ST_MRST_BIT = 1;
	localparam int ST_ROM_SERIAL_OUT_BIT_BIT = 2;
	// ****************************************************************
	// Reset values and encodings
	// ****************************************************************
	localparam logic [7:0] RESET_REG_INIT = 8'h00;
	localparam logic [7:0] BOOT_REG_INIT = 8'h00;
	localparam logic [7:0] EE_REG_INIT = 8'h00;
	localparam logic [7:0] ID_REG_INIT = 8'h00;
	localparam logic [7:0] MASK_REG_INIT = 8'h00;
	localparam logic [7:0] BOOT_SEC_MASK = 8'hFE;
	localparam logic [1:0] BOOT_LINK = 2'h0;
	localparam logic [1:0] BOOT_HOST = 2'h1;
	localparam logic [1:0] BOOT_PROM = 2'h2;
	localparam logic [1:0] BOOT_NONE = 2'h3;
	localparam logic [31:0] NOBOOT_START_ADDR = 32'h0040_0004;
	localparam int EEPROM_BITS = 1024;
	localparam int EEPROM_WORDS = 64;
	localparam int EEPROM_WORD_W = 16;
	// ****************************************************************
	// APB register map of the host controller
	// ****************************************************************
	localparam logic [11:0] APB_CMD = 12'h000;
	localparam logic [11:0] APB_STAT = 12'h004;
	localparam logic [11:0] APB_CTRL = 12'h008;
	localparam logic [11:0] APB_FLAGS = 12'h00C;
	localparam int CMD_WDATA_LSB = 0;
	localparam int CMD_ADDR_LSB = 8;
	localparam int CMD_WRITE_BIT = 12;
	localparam int STAT_RDATA_LSB = 0;
	localparam int STAT_BUSY_BIT = 8;
	localparam int STAT_SENSE_BIT = 9;
	localparam int CTRL_MRST_BIT = 0;
	localparam int CTRL_BOOT_LSB = 1;
	// ****************************************************************
	// Host controller states
	// ****************************************************************
	typedef enum logic [1:0] {
		MCI_IDLE,
		MCI_SETUP,
		MCI_STROBE,
		MCI_HOLD
	} mci_state_t;
endpackage

// File: sim/mci_asserts.sv
// Concurrent checks on the control bus between the two ends.
`timescale 1ns/100ps
module mci_asserts (
	input wire logic i_core_clk, // bus clock
	input wire logic i_nrst, // async reset, active low
	input wire logic [3:0] addr, // port address
	input wire logic [7:0] wdata, // write data
	input wire logic [7:0] rdata, // read data
	input wire logic wr_stb, // write strobe
	input wire logic rd_en, // read cycle
	input wire logic mrst_n // module reset, active low
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	AST_IDLE: assert property (!rd_en |-> rdata == 8'h00)
		else $error("read data set outside a read");
	AST_STB: assert property (wr_stb |=> !wr_stb && !rd_en)
		else $error("write strobe longer than one cycle");
	AST_RDLEN: assert property ($rose(rd_en) |-> rd_en[*3] ##1 !rd_en)
		else $error("read cycle not three cycles");
	AST_WRSTAB: assert property (wr_stb |-> $stable(addr) && $stable(wdata))
		else $error("address or data moved at strobe");
	// Read data is registered one cycle after the address, so port
	// contents are only judged from the second cycle of a read on.
	AST_OPT: assert property (rd_en && $past(rd_en) && addr >= 4'h7
		|-> rdata == 8'h00)
		else $error("optional port read not zero");
	AST_GEN: assert property (rd_en && $past(rd_en)
		&& addr == mci_pkg::PORT_IRQ_GEN |-> rdata == 8'h00)
		else $error("generate port read not zero");
	AST_EE: assert property (rd_en && $past(rd_en)
		&& addr == mci_pkg::PORT_EEPROM
		|-> rdata[7:4] == 4'h0 && rdata[2:0] == 3'h0)
		else $error("eeprom port write-only bits read set");
	AST_BOOT0: assert property (rd_en && $past(rd_en)
		&& addr == mci_pkg::PORT_BOOT |-> !rdata[0])
		else $error("unused boot bit read set");
	// Reset needs two synchroniser stages, one register update and the
	// read-data register before the run bits read back as zero.
	AST_RST: assert property ((!mrst_n)[*5] ##0 rd_en
		&& $past(rd_en) && addr == mci_pkg::PORT_RESET
		|-> rdata == 8'h00)
		else $error("run bits set during module reset");
	cover property (wr_stb && addr == mci_pkg::PORT_IRQ_GEN);
	cover property (rd_en && addr == mci_pkg::PORT_EEPROM);
	cover property (rd_en && !mrst_n);
endmodule

// File: sim/module_control_interface_tb.sv
// Testbench joining carrier and module ends of the control bus.
`timescale 1ns/100ps
module module_control_interface_tb;
	// ****************************************************************
	// Signals and ends
	// ****************************************************************
	logic clk = 0, nrst = 0, psel = 0, pen = 0, pw = 0;
	logic [11:0] pa = 0;
	logic [31:0] pwd = 0, prd, rd, seed = 32'h0000_6f5c;
	logic rdy, serr, err, pres = 0, tdi = 0, tdo, dout = 0, cs, sk, di;
	logic [7:0] rstn, bh, pid, irq, v, irq_v;
	logic [7:0] sh [16] = '{default: 8'h00};
	logic [1:0] pb;
	logic [3:0] hf = 0, df = 0, ohf, odf;
	int err_total = 0, samples_checked = 0, irq_n = 0;
	mci_if bus_if ();
	mci_module i_mci_module (.i_core_clk(clk), .i_nrst(nrst), .bus(bus_if),
		.i_present(pres), .i_tdi(tdi), .o_tdo(tdo),
		.i_rom_serial_out_bit(dout), .o_rom_select_bit(cs),
		.o_rom_serial_clock_bit(sk), .o_rom_serial_in_bit(di),
		.o_proc_rst_n(rstn), .o_boot_host(bh), .o_primary_boot(pb),
		.o_proc_id(pid), .o_lowest_interrupt_input(irq),
		.i_dev_flags(df), .o_dev_flags(odf));
	mci_host i_mci_host (.i_core_clk(clk), .i_nrst(nrst), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pw), .i_paddr(pa), .i_pwdata(pwd),
		.o_prdata(prd), .o_pready(rdy), .o_pslverr(serr), .bus(bus_if),
		.i_host_flags(hf), .o_host_flags(ohf));
	mci_asserts i_mci_asserts (.i_core_clk(clk), .i_nrst(nrst),
		.addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
		.wr_stb(bus_if.wr_stb), .rd_en(bus_if.rd_en),
		.mrst_n(bus_if.mrst_n));
	always #12.5 clk = ~clk;
	// Pulses are counted so a stretched interrupt shows as a count above one.
	always @(posedge clk)
		if (|irq)
		begin
			irq_n++;
			irq_v <= irq;
		end
	// ****************************************************************
	// Helpers
	// ****************************************************************
	function logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function logic [7:0] exp_port(input int p, input logic [7:0] w);
		case (p)
			0, 3, 5: return w;
			1: return w & 8'hFE;
			2: return {4'h0, dout, 3'h0};
			4: return {5'h00, dout, 1'b1, pres};
			default: return 8'h00;
		endcase
	endfunction
	task chk(input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			err_total++;
			$display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pw <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (rdy !== 1'b1)
			@(posedge clk);
		rd = prd;
		err = serr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(negedge clk);
	endtask
	task port(input logic w, input logic [3:0] p, input logic [7:0] d);
		irq_n = 0;
		irq_v = 8'h00;
		apb(1'b1, mci_pkg::APB_CMD, {19'h0_0000, w, p, d});
		apb(1'b0, mci_pkg::APB_STAT, 32'h0);
		while (rd[8] !== 1'b0)
			apb(1'b0, mci_pkg::APB_STAT, 32'h0);
	endtask
	task pins;
		chk(rstn, sh[0]);
		chk(bh, sh[1] & 8'hFE);
		chk({di, sk, cs}, sh[2][2:0]);
		chk(pid, sh[3]);
		chk(tdo, tdi);
		chk(odf, hf);
	endtask
	// ****************************************************************
	// Tests
	// ****************************************************************
	initial
	begin
		#500_000;
		err_total++;
		report_and_stop;
	end
	initial
	begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		apb(1'b1, mci_pkg::APB_CTRL, 32'h0);
		for (int p = 0; p < 16; p++)
		begin
			port(1'b0, p[3:0], 8'h00);
			chk(rd[7:0], exp_port(p, 8'h00));
		end
		$display("power-up test done");
		for (int k = 0; k < 4; k++)
		begin
			@(posedge clk);
			pres <= seed[0];
			dout <= seed[1];
			tdi <= seed[2];
			hf <= seed[7:4];
			df <= seed[11:8];
			for (int p = 0; p < 16; p++)
			begin
				seed = xs(seed);
				v = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : seed[7:0];
				port(1'b1, p[3:0], v);
				sh[p] = v;
				if (p == 6)
				begin
					chk(irq_v, sh[5]);
					chk(irq_n, |sh[5]);
				end
				port(1'b0, p[3:0], 8'h00);
				chk(rd[7:0], exp_port(p, v));
				pins();
			end
			apb(1'b0, mci_pkg::APB_FLAGS, 32'h0);
			chk(rd[3:0], df);
			chk(ohf, df);
			apb(1'b0, mci_pkg::APB_STAT, 32'h0);
			chk(rd[9], pres);
			apb(1'b0, 12'h010, 32'h0);
			chk(err, 1'b1);
			chk(rd, 32'h0000_0000);
			apb(1'b1, mci_pkg::APB_CTRL, {29'h0, k[1:0], 1'b1});
			chk(rstn, 8'h00);
			port(1'b0, 4'h0, 8'h00);
			chk(rd[7:0], 8'h00);
			apb(1'b1, mci_pkg::APB_CTRL, {29'h0, k[1:0], 1'b0});
			chk(pb, k[1:0]);
			sh = '{default: 8'h00};
			pins();
			$display("pass %0d done", k);
		end
		report_and_stop;
	end
endmodule
